// ---- design/queue_core.sv ----
// queue_core: first-in first-out queue, single- or dual-clock form.
// assumes: DEPTH is a power of two; one clock drives both sides, the
// dual form keeps its pointer crossings as stage delays.
//
// What this block does
// - near-full high when level at or above threshold
// - near-empty high when level below threshold
// - overflow protection ignores pushes while full
// - underflow protection ignores pops while empty
// - dual form writer drops push on full
// - dual form reader drops pop on empty
// - request drop holds whatever the clock ratio
// - single form requesters drop requests on flags
// - optional output register, off by default
// - related clocks use one synchroniser stage
// - near-empty follows level only, not data readiness
// - empty lags push by one write cycle, single form; dual form adds the read stages
// - thresholds and output register single form only
// - clock and stage options dual form only
// - optional clear synchroniser, write side
// - optional clear synchroniser, read side
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module queue_core import queue_pkg::*; #(
  parameter int DEPTH         = QUEUE_DEPTH,
  parameter int DW            = QUEUE_DATA_W,
  parameter bit DUAL_FORM     = 1'b0,
  parameter bit OVF_CHECK     = 1'b1,
  parameter bit UNF_CHECK     = 1'b1,
  parameter bit OUT_REG       = 1'b0,
  parameter int NEAR_FULL_TH  = NEAR_FULL_DEF,
  parameter int NEAR_EMPTY_TH = NEAR_EMPTY_DEF,
  parameter bit CLOCKS_SYNC   = 1'b0,
  parameter int WR_SYNC       = WR_SYNC_DEF,
  parameter int RD_SYNC       = RD_SYNC_DEF,
  parameter bit CLR_SYNC_WR   = 1'b0,
  parameter bit CLR_SYNC_RD   = 1'b0,
  parameter int AW            = $clog2(DEPTH),
  parameter int LW            = AW + 1
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  queue_if.dev      q,
  output logic      o_push_refused,
  output logic      o_pop_refused
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [LW-1:0] used_of(input logic [LW-1:0] wp,
                                            input logic [LW-1:0] rp);
    used_of = LW'(wp - rp);
  endfunction

  localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);
  localparam logic [LW-1:0] NF_TH_L = LW'(NEAR_FULL_TH);
  localparam logic [LW-1:0] NE_TH_L = LW'(NEAR_EMPTY_TH);
  // related clocks need only one retiming stage
  localparam int WS_EFF = CLOCKS_SYNC ? 1 : WR_SYNC;
  localparam int RS_EFF = CLOCKS_SYNC ? 1 : RD_SYNC;

  ////////////////////////////////////////////////////////////////////////
  // storage and state

  logic [DW-1:0] mem [DEPTH];
  logic [LW-1:0] wr_ptr_q;
  logic [LW-1:0] wr_vis_q;
  logic [LW-1:0] rd_ptr_q;
  logic [LW-1:0] count_q;
  logic [DW-1:0] rdata_q;
  logic          push_ref_q;
  logic          pop_ref_q;

  logic          clr_wr;
  logic          clr_rd;
  logic [LW-1:0] rd_in_wr;
  logic [LW-1:0] wr_in_rd;
  logic          full_w;
  logic          empty_w;
  logic          push_ok;
  logic          pop_ok;

  ////////////////////////////////////////////////////////////////////////
  // clear paths

  generate
    if (CLR_SYNC_WR) begin : g_clr_wr
      stage_sync #(
        .STAGES (CLR_SYNC_STAGES),
        .WIDTH  (1)
      ) u_clr_wr (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (q.clear),
        .o_q   (clr_wr)
      );
    end else begin : g_clr_wr_raw
      assign clr_wr = q.clear;
    end

    if (CLR_SYNC_RD) begin : g_clr_rd
      stage_sync #(
        .STAGES (CLR_SYNC_STAGES),
        .WIDTH  (1)
      ) u_clr_rd (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (q.clear),
        .o_q   (clr_rd)
      );
    end else begin : g_clr_rd_raw
      assign clr_rd = q.clear;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pointer crossings, dual form only

  generate
    if (DUAL_FORM) begin : g_dual
      stage_sync #(
        .STAGES (WS_EFF),
        .WIDTH  (LW)
      ) u_rd2wr (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (rd_ptr_q),
        .o_q   (rd_in_wr)
      );
      stage_sync #(
        .STAGES (RS_EFF),
        .WIDTH  (LW)
      ) u_wr2rd (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (wr_vis_q),
        .o_q   (wr_in_rd)
      );
    end else begin : g_single
      assign rd_in_wr = rd_ptr_q;
      assign wr_in_rd = wr_vis_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // flags and request acceptance

  assign full_w  = DUAL_FORM ? (used_of(wr_ptr_q, rd_in_wr) == DEPTH_L)
                             : (count_q == DEPTH_L);
  // empty looks at the visible write pointer, a cycle behind the push
  assign empty_w = (wr_in_rd == rd_ptr_q);

  assign push_ok = q.push && !(OVF_CHECK && full_w);
  assign pop_ok  = q.pop && !(UNF_CHECK && empty_w);

  ////////////////////////////////////////////////////////////////////////
  // write side

  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem[wr_ptr_q[AW-1:0]] <= q.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
    end else if (clr_wr) begin
      wr_ptr_q <= '0;
    end else if (push_ok) begin
      wr_ptr_q <= LW'(wr_ptr_q + 1'b1);
    end
  end

  // write latency: a word becomes readable one cycle after its push
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_vis_q <= '0;
    end else if (clr_wr) begin
      wr_vis_q <= '0;
    end else begin
      wr_vis_q <= wr_ptr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read side

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_ptr_q <= '0;
    end else if (clr_rd) begin
      rd_ptr_q <= '0;
    end else if (pop_ok) begin
      rd_ptr_q <= LW'(rd_ptr_q + 1'b1);
    end
  end

  // optional pipeline stage on the head word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (clr_rd) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[rd_ptr_q[AW-1:0]];
    end
  end

  // output register exists only in the single form
  assign q.rdata = (OUT_REG && !DUAL_FORM) ? rdata_q
                                           : mem[rd_ptr_q[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////
  // fill level

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (clr_wr || clr_rd) begin
      count_q <= '0;
    end else begin
      case ({push_ok, pop_ok})
        2'b10:   count_q <= LW'(count_q + 1'b1);
        2'b01:   count_q <= LW'(count_q - 1'b1);
        default: count_q <= count_q;
      endcase
    end
  end

  assign q.level = DUAL_FORM ? used_of(wr_ptr_q, rd_in_wr) : count_q;
  assign q.full  = full_w;
  assign q.empty = empty_w;

  // thresholds only in the single form; both look at level alone
  assign q.near_full  = !DUAL_FORM && (count_q >= NF_TH_L);
  assign q.near_empty = !DUAL_FORM && (count_q < NE_TH_L);

  ////////////////////////////////////////////////////////////////////////
  // refused request pulses

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      push_ref_q <= 1'b0;
      pop_ref_q  <= 1'b0;
    end else begin
      push_ref_q <= q.push && !push_ok;
      pop_ref_q  <= q.pop && !pop_ok;
    end
  end

  assign o_push_refused = push_ref_q;
  assign o_pop_refused  = pop_ref_q;

endmodule

// ---- design/queue_pkg.sv ----
// queue_pkg: shared constants of the queue and of its controller.
// assumes: included in compile order before every other design file.
package queue_pkg;

  // default shape of the queue
  localparam int QUEUE_DEPTH     = 16;
  localparam int QUEUE_DATA_W    = 8;
  localparam int NEAR_FULL_DEF   = 12;
  localparam int NEAR_EMPTY_DEF  = 2;
  localparam int WR_SYNC_DEF     = 3;
  localparam int RD_SYNC_DEF     = 3;
  localparam int CLR_SYNC_STAGES = 2;

  // controller register map (byte addresses, one word each)
  localparam logic [7:0] OFS_DATA     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_LEVEL    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0] OFS_CTRL     = 8'h18;

  // flag positions, shared by status, irq status, clear and enable
  localparam int BIT_FULL       = 0;
  localparam int BIT_EMPTY      = 1;
  localparam int BIT_NEAR_FULL  = 2;
  localparam int BIT_NEAR_EMPTY = 3;
  localparam int FLAG_W         = 4;

  // control register: bit 0 pulses the queue clear
  localparam int BIT_CTRL_CLEAR = 0;

  // reset values
  localparam logic [FLAG_W-1:0] IRQ_EN_RST = 4'h0;
  localparam logic [31:0]       RDATA_RST  = 32'h0000_0000;
  // flags as reset leaves them: empty and near-empty high
  localparam logic [FLAG_W-1:0] FLAGS_RST  = 4'ha;

  // cycles the controller waits after a push or pop before head data
  // is trusted (head path plain / with output register)
  localparam logic [1:0] SETTLE_PLAIN = 2'h1;
  localparam logic [1:0] SETTLE_OREG  = 2'h2;

endpackage

// ---- design/queue_if.sv ----
// queue_if: push/pop link between the queue and its controller.
// assumes: both ends run on the same clock and reset.
`timescale 1ns/1ps
interface queue_if #(
  parameter int DW = 8,
  parameter int LW = 5
);
  logic          push;
  logic          pop;
  logic          clear;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic          full;
  logic          empty;
  logic          near_full;
  logic          near_empty;
  logic [LW-1:0] level;

  modport dev (
    input  push, pop, clear, wdata,
    output rdata, full, empty, near_full, near_empty, level
  );

  modport ctl (
    output push, pop, clear, wdata,
    input  rdata, full, empty, near_full, near_empty, level
  );
endinterface

// ---- design/stage_sync.sv ----
// stage_sync: chain of flip-flops carrying a value across a boundary.
// assumes: STAGES >= 1; first stage is read only by the second one.
`timescale 1ns/1ps
module stage_sync #(
  parameter int STAGES = 2,
  parameter int WIDTH  = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] chain_q [STAGES];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_q[i] <= '0;
      end
    end else begin
      chain_q[0] <= i_d;
      for (int i = 1; i < STAGES; i++) begin
        chain_q[i] <= chain_q[i-1];
      end
    end
  end

  assign o_q = chain_q[STAGES-1];

endmodule

// ---- design/queue_ctl.sv ----
// queue_ctl: APB register front end that pushes to and pops from the
// queue, with sticky flag interrupts.
// assumes: same clock and reset as the queue; OUT_REG matches it.
`timescale 1ns/1ps
module queue_ctl import queue_pkg::*; #(
  parameter int DW      = QUEUE_DATA_W,
  parameter int LW      = 5,
  parameter bit OUT_REG = 1'b0
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  queue_if.ctl             q
);

  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              irq_q;
  logic              push_q;
  logic              pop_q;
  logic              clear_q;
  logic [DW-1:0]     wdata_q;
  logic [1:0]        settle_q;
  logic [FLAG_W-1:0] irq_stat_q;
  logic [FLAG_W-1:0] irq_en_q;
  logic [FLAG_W-1:0] flags_prev_q;

  logic              access;
  logic              done;
  logic              is_data;
  logic              can_go;
  logic              mapped;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] rise;
  logic [31:0]       rd_val;

  assign flags = {q.near_empty, q.near_full, q.empty, q.full};
  assign rise  = flags & ~flags_prev_q;

  assign access  = i_psel && i_penable && !pready_q;
  assign done    = i_psel && i_penable && pready_q;
  assign is_data = (i_paddr == OFS_DATA);
  // data access waits until the queue can take or give a word
  assign can_go  = !is_data ||
                   (i_pwrite ? (!q.full && !push_q)
                             : (!q.empty && !pop_q && settle_q == 2'h0));

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (i_paddr)
      OFS_DATA:     rd_val = 32'(q.rdata);
      OFS_STATUS:   rd_val = 32'(flags);
      OFS_LEVEL:    rd_val = 32'(q.level);
      OFS_IRQ_STAT: rd_val = 32'(irq_stat_q);
      OFS_IRQ_EN:   rd_val = 32'(irq_en_q);
      OFS_IRQ_CLR:  rd_val = 32'h0000_0000;
      OFS_CTRL:     rd_val = 32'h0000_0000;
      default:      mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_RST;
    end else if (access && can_go) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q  <= i_pwrite ? RDATA_RST : rd_val;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // requests: one-cycle pulses; push and pop only while the flag permits

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      push_q  <= 1'b0;
      pop_q   <= 1'b0;
      clear_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      push_q  <= done && is_data && i_pwrite && !q.full;
      pop_q   <= done && is_data && !i_pwrite && !q.empty;
      clear_q <= done && i_pwrite && (i_paddr == OFS_CTRL) &&
                 i_pwdata[BIT_CTRL_CLEAR];
      if (done && is_data && i_pwrite) begin
        wdata_q <= i_pwdata[DW-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_q <= 2'h0;
    end else if (push_q || pop_q) begin
      settle_q <= OUT_REG ? SETTLE_OREG : SETTLE_PLAIN;
    end else if (settle_q != 2'h0) begin
      settle_q <= settle_q - 2'h1;
    end
  end

  assign q.push  = push_q;
  assign q.pop   = pop_q;
  assign q.clear = clear_q;
  assign q.wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupts: rising flags are sticky, set wins over clear

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      // start from the reset flags, so no false rise after reset
      flags_prev_q <= FLAGS_RST;
      irq_stat_q   <= '0;
      irq_en_q     <= IRQ_EN_RST;
      irq_q        <= 1'b0;
    end else begin
      flags_prev_q <= flags;
      if (done && i_pwrite && i_paddr == OFS_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~i_pwdata[FLAG_W-1:0]) | rise;
      end else begin
        irq_stat_q <= irq_stat_q | rise;
      end
      if (done && i_pwrite && i_paddr == OFS_IRQ_EN) begin
        irq_en_q <= i_pwdata[FLAG_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_irq     = irq_q;

endmodule

// ---- bench/queue_chk.sv ----
// queue_chk: assertions on the push/pop link of the queue.
// assumes: one clock, async active-high reset, clear not synchronised.
`timescale 1ns/1ps
module queue_chk import queue_pkg::*; #(
  parameter int LW    = 5,
  parameter int NF_TH = NEAR_FULL_DEF,
  parameter int NE_TH = NEAR_EMPTY_DEF
) (
  input wire logic          i_clk,
  input wire logic          i_rst,
  input wire logic          push,
  input wire logic          pop,
  input wire logic          clear,
  input wire logic          full,
  input wire logic          empty,
  input wire logic          near_full,
  input wire logic          near_empty,
  input wire logic [LW-1:0] level
);
  logic acc_wr;
  logic acc_rd;

  assign acc_wr = push && !full;
  assign acc_rd = pop && !empty;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////
  near_full_a: assert property (near_full == (level >= NF_TH))
    else $error("near_full disagrees with level");
  near_empty_a: assert property (near_empty == (level < NE_TH))
    else $error("near_empty disagrees with level");
  level_up_a: assert property (
    acc_wr && !acc_rd && !clear |=> level == $past(level) + 1'b1)
    else $error("level did not rise on push");
  level_down_a: assert property (
    acc_rd && !acc_wr && !clear |=> level == $past(level) - 1'b1)
    else $error("level did not fall on pop");
  level_hold_a: assert property (
    acc_wr == acc_rd && !clear |=> $stable(level))
    else $error("level moved without net transfer");
  push_drop_a: assert property (full |-> !push)
    else $error("push presented while full");
  pop_drop_a: assert property (empty |-> !pop)
    else $error("pop presented while empty");
  empty_lag_a: assert property (
    (level == '0 && push && !clear) ##1 !clear
      |-> (empty && level == 1) ##1 !empty)
    else $error("empty did not lag the first push");
  clear_now_a: assert property (clear |=> level == '0 && empty)
    else $error("clear left data behind");
endmodule

// ---- bench/testbench.sv ----
// testbench: controller and core joined by the queue link, plus two
// cores driven directly: refusals and clear sync on the second, the
// dual form unprotected on the third.
// assumes: one 100 MHz clock; default shape, second core threshold 1.
`timescale 1ns/1ps
module testbench;
  import queue_pkg::*;

  logic        i_clk;
  logic        i_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ref_wr;
  logic        ref_rd;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          samples_checked;
  int          cycles;

  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
  } row_s;

  localparam row_s ROWS [21] = '{
    '{1'b0, OFS_IRQ_EN, 32'h0},
    '{1'b0, OFS_IRQ_STAT, 32'h0},
    '{1'b0, OFS_IRQ_STAT, 32'h0},
    '{1'b0, OFS_STATUS, 32'ha},
    '{1'b0, OFS_LEVEL, 32'h0},
    '{1'b1, OFS_DATA, 32'h5a},
    '{1'b1, OFS_DATA, 32'h3c},
    '{1'b0, OFS_LEVEL, 32'h2},
    '{1'b0, OFS_STATUS, 32'h0},
    '{1'b0, OFS_DATA, 32'h5a},
    '{1'b0, OFS_DATA, 32'h3c},
    '{1'b0, OFS_LEVEL, 32'h0},
    '{1'b0, OFS_STATUS, 32'ha},
    '{1'b0, 8'h1c, 32'h0},
    '{1'b1, 8'h20, 32'h1},
    '{1'b0, OFS_IRQ_CLR, 32'h0},
    '{1'b0, OFS_IRQ_STAT, 32'ha},
    '{1'b1, OFS_IRQ_CLR, 32'hf},
    '{1'b0, OFS_IRQ_STAT, 32'h0},
    '{1'b1, OFS_IRQ_EN, 32'h1},
    '{1'b0, OFS_IRQ_EN, 32'h1}
  };

  queue_if #(.DW(QUEUE_DATA_W), .LW(5)) q ();
  queue_if #(.DW(QUEUE_DATA_W), .LW(5)) q2 ();
  queue_if #(.DW(QUEUE_DATA_W), .LW(5)) q3 ();

  queue_ctl u_queue_ctl (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .q(q));
  queue_core u_queue_core (
    .i_clk(i_clk), .i_rst(i_rst), .q(q),
    .o_push_refused(), .o_pop_refused());
  queue_core #(.NEAR_EMPTY_TH(1), .CLR_SYNC_WR(1'b1),
               .CLR_SYNC_RD(1'b1)) u_queue_core_2 (
    .i_clk(i_clk), .i_rst(i_rst), .q(q2),
    .o_push_refused(ref_wr), .o_pop_refused(ref_rd));
  queue_core #(.DUAL_FORM(1'b1), .OVF_CHECK(1'b0),
               .UNF_CHECK(1'b0)) u_queue_core_3 (
    .i_clk(i_clk), .i_rst(i_rst), .q(q3),
    .o_push_refused(), .o_pop_refused());
  queue_chk #(.LW(5)) u_queue_chk (
    .i_clk(i_clk), .i_rst(i_rst), .push(q.push), .pop(q.pop),
    .clear(q.clear), .full(q.full), .empty(q.empty),
    .near_full(q.near_full), .near_empty(q.near_empty), .level(q.level));

  ////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    q2.push = 1'b0;
    q2.pop = 1'b0;
    q2.clear = 1'b0;
    q2.wdata = 8'ha5;
    q3.push = 1'b0;
    q3.pop = 1'b0;
    q3.clear = 1'b0;
    q3.wdata = 8'h3c;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) chk("read data", ROWS[i].d, rd);
      chk("slave error", 32'(ROWS[i].a > OFS_CTRL), 32'(err));
    end
    // fill to full, watching near-full and the interrupt
    for (int i = 0; i < QUEUE_DEPTH; i++) begin
      apb(1'b1, OFS_DATA, 32'(i + 8'h40));
      if (i == NEAR_FULL_DEF - 2) rdk(OFS_STATUS, 32'h0);
      if (i == NEAR_FULL_DEF - 1) rdk(OFS_STATUS, 32'h4);
    end
    rdk(OFS_STATUS, 32'h5);
    rdk(OFS_LEVEL, 32'(QUEUE_DEPTH));
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge i_clk);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    for (int i = 0; i < QUEUE_DEPTH; i++) rdk(OFS_DATA, 32'(i + 8'h40));
    rdk(OFS_STATUS, 32'ha);
    // clear through the control register
    repeat (3) apb(1'b1, OFS_DATA, 32'h11);
    apb(1'b1, OFS_CTRL, 32'h1);
    rdk(OFS_LEVEL, 32'h0);
    rdk(OFS_STATUS, 32'ha);
    // second core: pop while empty, then push past full
    @(posedge i_clk);
    q2.pop <= 1'b1;
    @(posedge i_clk);
    q2.pop <= 1'b0;
    @(posedge i_clk);
    chk("pop refused", 32'h1, 32'(ref_rd));
    chk("level after refusal", 32'h0, 32'(q2.level));
    q2.push <= 1'b1;
    repeat (QUEUE_DEPTH + 1) @(posedge i_clk);
    q2.push <= 1'b0;
    @(posedge i_clk);
    chk("push refused", 32'h1, 32'(ref_wr));
    chk("level when full", 32'(QUEUE_DEPTH), 32'(q2.level));
    q2.pop <= 1'b1;
    repeat (QUEUE_DEPTH) @(posedge i_clk);
    q2.pop <= 1'b0;
    q2.push <= 1'b1;
    @(posedge i_clk);
    q2.push <= 1'b0;
    @(posedge i_clk);
    chk("empty lags push", 32'h1, 32'(q2.empty));
    chk("near empty on level", 32'h0, 32'(q2.near_empty));
    chk("level one", 32'h1, 32'(q2.level));
    @(posedge i_clk);
    chk("empty falls", 32'h0, 32'(q2.empty));
    // second core: clear passes its synchronisers before acting
    q2.clear <= 1'b1;
    @(posedge i_clk);
    q2.clear <= 1'b0;
    repeat (CLR_SYNC_STAGES) @(posedge i_clk);
    chk("clear held back", 32'h1, 32'(q2.level));
    @(posedge i_clk);
    chk("level cleared", 32'h0, 32'(q2.level));
    chk("empty cleared", 32'h1, 32'(q2.empty));
    // third core, dual form: crossing lag, unprotected fill and drain
    chk("dual near empty", 32'h0, 32'(q3.near_empty));
    q3.push <= 1'b1;
    @(posedge i_clk);
    q3.push <= 1'b0;
    repeat (RD_SYNC_DEF + 1) @(posedge i_clk);
    chk("dual empty lag", 32'h1, 32'(q3.empty));
    @(posedge i_clk);
    chk("dual empty falls", 32'h0, 32'(q3.empty));
    q3.push <= 1'b1;
    repeat (QUEUE_DEPTH - 1) @(posedge i_clk);
    q3.push <= 1'b0;
    @(posedge i_clk);
    chk("dual full", 32'h1, 32'(q3.full));
    chk("dual near full", 32'h0, 32'(q3.near_full));
    chk("dual level full", 32'(QUEUE_DEPTH), 32'(q3.level));
    q3.pop <= 1'b1;
    repeat (QUEUE_DEPTH) @(posedge i_clk);
    q3.pop <= 1'b0;
    @(posedge i_clk);
    chk("dual empty", 32'h1, 32'(q3.empty));
    chk("dual level lag", 32'(WR_SYNC_DEF), 32'(q3.level));
    repeat (WR_SYNC_DEF) @(posedge i_clk);
    chk("dual level drained", 32'h0, 32'(q3.level));
    // reset in mid-run with a word stored
    apb(1'b1, OFS_DATA, 32'h77);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk("level after reset", 32'h0, 32'(q.level));
    chk("empty after reset", 32'h1, 32'(q.empty));
    complete_run();
  end
endmodule
